/* rrp_target.sv */
`timescale 1ns/10ps
`default_nettype none
module rrp_target
	import rrp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	rrp_if.target           link,
	input  wire logic       media_valid,
	input  wire rrp_blk_e   media_status,
	output logic            media_req,
	input  wire logic [7:0] buf_level,
	output logic [7:0]      read_thr,
	output logic [7:0]      write_thr
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_XFER,
		ST_STATUS
	} rrp_state_e;
	rrp_state_e  state_reg;       // command sequencer
	logic        per_reg;         // post_error flag
	logic        dte_reg;         // stop_on_error flag
	logic        dcr_reg;         // no_correction flag
	logic        tb_reg;          // send_bad_block flag
	logic [2:0]  act_flags_reg;   // flags latched for the running command
	logic        act_tb_reg;      // send_bad_block latched for the command
	logic        is_read_reg;     // running command reads
	logic [31:0] lba_reg;         // current block
	logic [15:0] left_reg;        // blocks remaining
	logic        rec_seen_reg;    // a recovered or unrecoverable block occurred
	logic [31:0] rec_lba_reg;     // last recovered or unrecoverable block
	logic        pg_bad_reg;      // unsupported field nonzero
	logic        pg_hdr_bad_reg;  // code or length wrong
	logic [7:0]  rd_buf_reg;      // pending read threshold
	logic [7:0]  wr_buf_reg;      // pending write threshold
	logic        thr_load;        // commit page thresholds
	logic        pg_ok;           // page passes checks
	logic        fixable;         // block can be delivered
	logic        recovered;       // block needed recovery
	logic        stop_now;        // transfer ends on this block
	logic        key_medium_reg;  // transfer ended on an unrecoverable block
	// ----------------------------------------------------------------
	// thresholds
	// ----------------------------------------------------------------
	rrp_thr #(.DEFAULT_VAL(READ_THR_RESET)) u_rd_thr (
		.clk   (clk),
		.rstn  (rstn),
		.load  (thr_load),
		.value (rd_buf_reg),
		.thr   (read_thr)
	);
	rrp_thr #(.DEFAULT_VAL(WRITE_THR_RESET)) u_wr_thr (
		.clk   (clk),
		.rstn  (rstn),
		.load  (thr_load),
		.value (wr_buf_reg),
		.thr   (write_thr)
	);
	// ----------------------------------------------------------------
	// page write checks
	// ----------------------------------------------------------------
	// page accepted only with good header and zero unsupported fields
	assign pg_ok = !pg_bad_reg && !pg_hdr_bad_reg;
	assign thr_load = link.pg_valid && link.pg_last && pg_ok && state_reg == ST_IDLE;
	// collect page bytes, flag nonzero reserved limits
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pg_bad_reg     <= 1'b0;
			pg_hdr_bad_reg <= 1'b0;
			rd_buf_reg     <= 8'h00;
			wr_buf_reg     <= 8'h00;
		end else if (link.pg_valid && link.pg_last) begin
			pg_bad_reg     <= 1'b0;
			pg_hdr_bad_reg <= 1'b0;
		end else if (link.pg_valid) begin
			unique case (link.pg_idx)
				OFS_PAGE_CODE: pg_hdr_bad_reg <= pg_hdr_bad_reg | (link.pg_data[5:0] != PAGE_CODE_DISC);
				OFS_PAGE_LEN: pg_hdr_bad_reg <= pg_hdr_bad_reg |
					(link.pg_data != PAGE_LEN_DISC && link.pg_data != 8'h00);
				OFS_READ_THR: rd_buf_reg <= link.pg_data;
				OFS_WRITE_THR: wr_buf_reg <= link.pg_data;
				OFS_DETACH_CTL: pg_bad_reg <= pg_bad_reg | link.pg_data[DTC_BIT];
				default: begin
					// limit and burst fields must be zero
					if (link.pg_idx >= OFS_IDLE_MSB && link.pg_idx < OFS_DETACH_CTL)
						pg_bad_reg <= pg_bad_reg | (link.pg_data != 8'h00);
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// recovery flag store
	// ----------------------------------------------------------------
	// flags stay until the next accepted flag write or reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			per_reg <= 1'b0;
			dte_reg <= 1'b0;
			dcr_reg <= 1'b0;
			tb_reg  <= 1'b0;
		end else if (link.cmd_valid && link.cmd_ready && link.cmd_type == RRP_CMD_FLAGS
			&& !(link.cmd_flags[1] && !link.cmd_flags[2])) begin
			per_reg <= link.cmd_flags[2];
			dte_reg <= link.cmd_flags[1];
			dcr_reg <= link.cmd_flags[0];
			tb_reg  <= link.cmd_tb;
		end
	end
	// ----------------------------------------------------------------
	// block classification
	// ----------------------------------------------------------------
	// ecc blocks are unrecoverable when correction is off
	always_comb begin
		fixable   = 1'b1;
		recovered = 1'b0;
		unique case (media_status)
			RRP_BLK_CLEAN: begin
				fixable = 1'b1;
			end
			RRP_BLK_RETRY: begin
				recovered = 1'b1;
			end
			RRP_BLK_ECC: begin
				fixable   = !act_flags_reg[0];
				recovered = !act_flags_reg[0];
			end
			RRP_BLK_BAD: begin
				fixable = 1'b0;
			end
		endcase
	end
	// stop on unrecoverable, or on any error in stop mode
	assign stop_now = !fixable || (recovered && act_flags_reg[1]) || left_reg == 16'h0001;
	assign link.cmd_ready = state_reg == ST_IDLE;
	assign media_req = state_reg == ST_XFER && is_read_reg;
	// reselect once buffer reaches the active threshold
	assign link.reselect = state_reg == ST_XFER &&
		(is_read_reg ? buf_level >= read_thr : buf_level <= write_thr);
	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg       <= ST_IDLE;
			act_flags_reg   <= 3'h0;
			act_tb_reg      <= 1'b0;
			is_read_reg     <= 1'b0;
			lba_reg         <= 32'h0000_0000;
			left_reg        <= 16'h0000;
			rec_seen_reg    <= 1'b0;
			rec_lba_reg     <= 32'h0000_0000;
			key_medium_reg  <= 1'b0;
			link.blk_valid  <= 1'b0;
			link.blk_lba    <= 32'h0000_0000;
			link.blk_fixed  <= 1'b0;
			link.done       <= 1'b0;
			link.chk_cond   <= 1'b0;
			link.sense_key  <= SK_NONE;
			link.sense_info <= 32'h0000_0000;
		end else begin
			link.blk_valid <= 1'b0;
			link.done      <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (link.cmd_valid && link.cmd_type == RRP_CMD_FLAGS) begin
						link.done       <= 1'b1;
						link.chk_cond   <= link.cmd_flags[1] && !link.cmd_flags[2];
						link.sense_key  <= (link.cmd_flags[1] && !link.cmd_flags[2]) ? SK_ILLEGAL : SK_NONE;
						link.sense_info <= 32'h0000_0000;
					end else if (link.pg_valid && link.pg_last) begin
						link.done       <= 1'b1;
						link.chk_cond   <= !pg_ok;
						link.sense_key  <= pg_ok ? SK_NONE : SK_ILLEGAL;
						link.sense_info <= 32'h0000_0000;
					end else if (link.cmd_valid && link.cmd_len == 16'h0000) begin
						link.done      <= 1'b1;
						link.chk_cond  <= 1'b0;
						link.sense_key <= SK_NONE;
					end else if (link.cmd_valid) begin
						state_reg     <= ST_XFER;
						act_flags_reg <= {per_reg, dte_reg, dcr_reg};
						act_tb_reg    <= tb_reg;
						is_read_reg   <= link.cmd_type == RRP_CMD_READ;
						lba_reg       <= link.cmd_lba;
						left_reg      <= link.cmd_len;
						rec_seen_reg  <= 1'b0;
						key_medium_reg <= 1'b0;
					end
				end
				ST_XFER: begin
					if (!is_read_reg) begin
						// writes complete block by block without media errors
						lba_reg  <= lba_reg + 32'h0000_0001;
						left_reg <= left_reg - 16'h0001;
						if (left_reg == 16'h0001) begin
							state_reg <= ST_STATUS;
						end
					end else if (media_valid) begin
						// deliver good blocks, bad ones only with send_bad_block
						link.blk_valid <= fixable || act_tb_reg;
						link.blk_lba   <= lba_reg;
						link.blk_fixed <= recovered;
						lba_reg        <= lba_reg + 32'h0000_0001;
						left_reg       <= left_reg - 16'h0001;
						if (recovered) begin
							rec_seen_reg <= 1'b1;
							rec_lba_reg  <= lba_reg;
						end
						if (stop_now) begin
							state_reg <= ST_STATUS;
							if (!fixable) begin
								// unrecoverable block ends every mode
								rec_seen_reg <= 1'b1;
								rec_lba_reg  <= lba_reg;
								act_tb_reg   <= 1'b0;
								act_flags_reg[2] <= 1'b1;
								key_medium_reg   <= 1'b1;
							end
						end
					end
				end
				ST_STATUS: begin
					// recovered errors are reported only with post_error
					state_reg       <= ST_IDLE;
					link.done       <= 1'b1;
					link.chk_cond   <= act_flags_reg[2] && rec_seen_reg;
					link.sense_info <= rec_lba_reg;
					if (!(act_flags_reg[2] && rec_seen_reg)) begin
						link.sense_key <= SK_NONE;
					end else if (key_medium_reg) begin
						// status outputs only move together with done
						link.sense_key <= SK_MEDIUM;
					end else begin
						link.sense_key <= SK_RECOVERED;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* rrp_pkg.sv */
`default_nettype none
package rrp_pkg;
	// ----------------------------------------------------------------
	// mode page layout
	// ----------------------------------------------------------------
	localparam logic [5:0] PAGE_CODE_DISC    = 6'h02;  // disconnect/reconnect page code
	localparam logic [7:0] PAGE_LEN_DISC     = 8'h0E;  // page length byte value
	localparam logic [3:0] OFS_PAGE_CODE     = 4'h0;   // page code byte
	localparam logic [3:0] OFS_PAGE_LEN      = 4'h1;   // page length byte
	localparam logic [3:0] OFS_READ_THR      = 4'h2;   // read reselect threshold
	localparam logic [3:0] OFS_WRITE_THR     = 4'h3;   // write reselect threshold
	localparam logic [3:0] OFS_IDLE_MSB      = 4'h4;   // idle bus limit msb
	localparam logic [3:0] OFS_DETACH_MSB    = 4'h6;   // detach time limit msb
	localparam logic [3:0] OFS_ATTACH_MSB    = 4'h8;   // attach time limit msb
	localparam logic [3:0] OFS_BURST_MSB     = 4'hA;   // burst size limit msb
	localparam logic [3:0] OFS_DETACH_CTL    = 4'hC;   // transfer detach control byte
	localparam logic [3:0] OFS_LAST          = 4'hF;   // last byte of the page
	localparam logic [7:0] READ_THR_RESET    = 8'h20;  // read threshold default
	localparam logic [7:0] WRITE_THR_RESET   = 8'hC0;  // write threshold default
	localparam int         DTC_BIT           = 0;      // detach control bit position
	// ----------------------------------------------------------------
	// sense keys and status
	// ----------------------------------------------------------------
	localparam logic [3:0] SK_NONE           = 4'h0;   // no sense
	localparam logic [3:0] SK_RECOVERED      = 4'h1;   // recovered error
	localparam logic [3:0] SK_MEDIUM         = 4'h3;   // medium error
	localparam logic [3:0] SK_ILLEGAL        = 4'h5;   // illegal request
	// command types from the initiator
	typedef enum logic [1:0] {
		RRP_CMD_READ,
		RRP_CMD_WRITE,
		RRP_CMD_PAGE,
		RRP_CMD_FLAGS
	} rrp_cmd_e;
	// per-block media outcome
	typedef enum logic [1:0] {
		RRP_BLK_CLEAN,
		RRP_BLK_RETRY,
		RRP_BLK_ECC,
		RRP_BLK_BAD
	} rrp_blk_e;
endpackage
`default_nettype wire

/* rrp_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface rrp_if;
	import rrp_pkg::*;
	logic        cmd_valid;  // initiator command strobe
	logic        cmd_ready;  // target can take a command
	rrp_cmd_e    cmd_type;   // kind of command
	logic [31:0] cmd_lba;    // first block address
	logic [15:0] cmd_len;    // block count
	logic [2:0]  cmd_flags;  // post_error, stop_on_error, no_correction
	logic        cmd_tb;     // send_bad_block flag
	logic        pg_valid;   // page byte strobe
	logic [3:0]  pg_idx;     // page byte index
	logic [7:0]  pg_data;    // page byte
	logic        pg_last;    // last byte of the page write
	logic        blk_valid;  // block data strobe to initiator
	logic [31:0] blk_lba;    // address of the block sent
	logic        blk_fixed;  // block data corrected
	logic        reselect;   // target asks to reconnect
	logic        done;       // status pulse
	logic        chk_cond;   // check condition status
	logic [3:0]  sense_key;  // sense key
	logic [31:0] sense_info; // information bytes
	modport target (input cmd_valid, cmd_type, cmd_lba, cmd_len, cmd_flags, cmd_tb,
		pg_valid, pg_idx, pg_data, pg_last, output cmd_ready, blk_valid, blk_lba,
		blk_fixed, reselect, done, chk_cond, sense_key, sense_info);
	modport initiator (output cmd_valid, cmd_type, cmd_lba, cmd_len, cmd_flags, cmd_tb,
		pg_valid, pg_idx, pg_data, pg_last, input cmd_ready, blk_valid, blk_lba,
		blk_fixed, reselect, done, chk_cond, sense_key, sense_info);
endinterface
`default_nettype wire

/* rrp_thr.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// threshold holder: zero written selects the default
// ----------------------------------------------------------------
module rrp_thr #(
	parameter logic [7:0] DEFAULT_VAL = 8'h00
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       load,
	input  wire logic [7:0] value,
	output logic      [7:0] thr
);
	// load or fall back to the default
	always_ff @(posedge clk) begin
		if (!rstn) begin
			thr <= DEFAULT_VAL;
		end else if (load) begin
			thr <= (value == 8'h00) ? DEFAULT_VAL : value;
		end
	end
endmodule
`default_nettype wire

/* rrp_initiator.sv */
`timescale 1ns/10ps
`default_nettype none
module rrp_initiator
	import rrp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	rrp_if.initiator         link,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire rrp_cmd_e    req_type,
	input  wire logic [31:0] req_lba,
	input  wire logic [15:0] req_len,
	input  wire logic [2:0]  req_flags,
	input  wire logic        req_tb,
	input  wire logic [7:0]  req_read_thr,
	input  wire logic [7:0]  req_write_thr,
	output logic             rsp_valid,
	output logic             rsp_chk,
	output logic [3:0]       rsp_key,
	output logic [31:0]      rsp_info
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PAGE,
		ST_WAIT
	} rrp_ist_e;
	rrp_ist_e   state_reg; // sequencer
	logic [3:0] idx_reg;   // page byte counter
	logic [7:0] rt_reg;    // read threshold to send
	logic [7:0] wt_reg;    // write threshold to send
	logic [7:0] pg_byte;   // byte for current index
	assign req_ready = state_reg == ST_IDLE;
	// page image: unsupported fields always zero
	always_comb begin
		pg_byte = 8'h00;
		unique case (idx_reg)
			OFS_PAGE_CODE: pg_byte = {2'b00, PAGE_CODE_DISC};
			OFS_PAGE_LEN: pg_byte = PAGE_LEN_DISC;
			OFS_READ_THR: pg_byte = rt_reg;
			OFS_WRITE_THR: pg_byte = wt_reg;
			default: pg_byte = 8'h00;
		endcase
	end
	// ----------------------------------------------------------------
	// request sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg      <= ST_IDLE;
			idx_reg        <= 4'h0;
			rt_reg         <= 8'h00;
			wt_reg         <= 8'h00;
			link.cmd_valid <= 1'b0;
			link.cmd_type  <= RRP_CMD_READ;
			link.cmd_lba   <= 32'h0000_0000;
			link.cmd_len   <= 16'h0000;
			link.cmd_flags <= 3'h0;
			link.cmd_tb    <= 1'b0;
			link.pg_valid  <= 1'b0;
			link.pg_idx    <= 4'h0;
			link.pg_data   <= 8'h00;
			link.pg_last   <= 1'b0;
			rsp_valid      <= 1'b0;
			rsp_chk        <= 1'b0;
			rsp_key        <= SK_NONE;
			rsp_info       <= 32'h0000_0000;
		end else begin
			rsp_valid      <= 1'b0;
			link.pg_valid  <= 1'b0;
			link.pg_last   <= 1'b0;
			link.cmd_valid <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (req_valid && req_type == RRP_CMD_PAGE) begin
						state_reg <= ST_PAGE;
						idx_reg   <= 4'h0;
						rt_reg    <= req_read_thr;
						wt_reg    <= req_write_thr;
					end else if (req_valid) begin
						state_reg      <= ST_WAIT;
						link.cmd_valid <= 1'b1;
						link.cmd_type  <= req_type;
						link.cmd_lba   <= req_lba;
						link.cmd_len   <= req_len;
						// stop mode with correction needs send_bad_block
						link.cmd_flags <= req_flags;
						link.cmd_tb    <= req_tb | (req_flags == 3'b110);
					end
				end
				ST_PAGE: begin
					link.pg_valid <= 1'b1;
					link.pg_idx   <= idx_reg;
					link.pg_data  <= pg_byte;
					link.pg_last  <= idx_reg == OFS_LAST;
					idx_reg       <= idx_reg + 4'h1;
					if (idx_reg == OFS_LAST) begin
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (link.done) begin
						state_reg <= ST_IDLE;
						rsp_valid <= 1'b1;
						rsp_chk   <= link.chk_cond;
						rsp_key   <= link.sense_key;
						rsp_info  <= link.sense_info;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* rrp_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// link checker: watches the target side of the command link
// ----------------------------------------------------------------
module rrp_props
	import rrp_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire rrp_cmd_e    cmd_type,
	input wire logic [15:0] cmd_len,
	input wire logic [2:0]  cmd_flags,
	input wire logic        pg_valid,
	input wire logic        pg_last,
	input wire logic        reselect,
	input wire logic        done,
	input wire logic        chk_cond,
	input wire logic [3:0]  sense_key,
	input wire logic [31:0] sense_info
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// flags command accepted by an idle target
	sequence s_take_flags;
		cmd_valid && cmd_ready && cmd_type == RRP_CMD_FLAGS;
	endsequence
	// stop requested without post-error reporting
	sequence s_bad_flags;
		s_take_flags ##0 cmd_flags[2:1] == 2'b01;
	endsequence
	// refusal status on the link
	sequence s_refused;
		done && chk_cond && sense_key == SK_ILLEGAL;
	endsequence
	// data transfer of nonzero length accepted
	sequence s_take_xfer;
		cmd_valid && cmd_ready && cmd_type inside {RRP_CMD_READ, RRP_CMD_WRITE} && cmd_len != 16'h0000;
	endsequence
	a_flags_refused: assert property (s_bad_flags |=> s_refused)
		else $error("stop without post-error not refused");
	a_flags_taken: assert property (s_take_flags ##0 cmd_flags[2:1] != 2'b01 |=> done && !chk_cond)
		else $error("legal flags not answered cleanly");
	a_xfer_busy: assert property (s_take_xfer |=> !cmd_ready [*2])
		else $error("target idle right after a transfer start");
	a_page_answer: assert property (pg_valid && pg_last && cmd_ready |=> done)
		else $error("page write not answered next cycle");
	a_resel_busy: assert property (reselect |-> !cmd_ready)
		else $error("reselect raised outside a transfer");
	a_done_idle: assert property (done |-> cmd_ready)
		else $error("status given while still busy");
	a_done_single: assert property (done |=> !done)
		else $error("status pulse longer than one cycle");
	a_status_hold: assert property (!done |-> $stable(chk_cond) && $stable(sense_key) && $stable(sense_info))
		else $error("status changed without a status pulse");
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import rrp_pkg::*;
;
	logic        clk, rstn, req_valid, req_ready, req_tb, rsp_valid, rsp_chk, media_valid, media_req, resel_seen;
	rrp_cmd_e    req_type;
	rrp_blk_e    media_status;
	rrp_blk_e    mq[$];
	logic [31:0] req_lba, rsp_info;
	logic [15:0] req_len;
	logic [2:0]  req_flags;
	logic [3:0]  rsp_key;
	logic [7:0]  req_rthr, req_wthr, buf_level, read_thr, write_thr, thr2_r, thr2_w;
	int          err_total, checks_done, blocks, lat, cyc, ticks, fixd;
	rrp_if       l();
	rrp_if       l2();
	// ----------------------------------------------------------------
	// design under test and checker
	// ----------------------------------------------------------------
	rrp_target rrp_target_i (.clk(clk), .rstn(rstn), .link(l.target), .media_valid(media_valid),
		.media_status(media_status), .media_req(media_req), .buf_level(buf_level), .read_thr(read_thr),
		.write_thr(write_thr));
	// second target fed by the bench to break the page rules
	rrp_target rrp_target_i2 (.clk(clk), .rstn(rstn), .link(l2.target), .media_valid(1'b0),
		.media_status(RRP_BLK_CLEAN), .media_req(), .buf_level(8'h00), .read_thr(thr2_r), .write_thr(thr2_w));
	rrp_initiator rrp_initiator_i (.clk(clk), .rstn(rstn), .link(l.initiator), .req_valid(req_valid),
		.req_ready(req_ready), .req_type(req_type), .req_lba(req_lba), .req_len(req_len), .req_flags(req_flags),
		.req_tb(req_tb), .req_read_thr(req_rthr), .req_write_thr(req_wthr), .rsp_valid(rsp_valid),
		.rsp_chk(rsp_chk), .rsp_key(rsp_key), .rsp_info(rsp_info));
	rrp_props rrp_props_i (.clk(clk), .rstn(rstn), .cmd_valid(l.cmd_valid), .cmd_ready(l.cmd_ready),
		.cmd_type(l.cmd_type), .cmd_len(l.cmd_len), .cmd_flags(l.cmd_flags), .pg_valid(l.pg_valid),
		.pg_last(l.pg_last), .reselect(l.reselect), .done(l.done), .chk_cond(l.chk_cond),
		.sense_key(l.sense_key), .sense_info(l.sense_info));
	always #12.5 clk = ~clk;
	// monitor: block count, reselect, status latency, run ceiling
	always @(posedge clk) begin
		ticks++;
		if (l.blk_valid) begin
			chk(l.blk_lba, 32'h0000_0064 + 32'(blocks));
			blocks++;
			fixd += int'(l.blk_fixed);
		end
		if (l.reselect) resel_seen = 1'b1;
		if (l.done) lat = cyc;
		cyc = (l.cmd_valid && l.cmd_ready) ? 0 : cyc + 1;
		if (ticks > 20000) begin
			err_total++;
			results();
		end
	end
	// media source: hands out queued outcomes while blocks are wanted
	always @(posedge clk) begin
		#1;
		media_valid = media_req && mq.size() > 0;
		if (media_valid) media_status = mq.pop_front();
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one request through the initiator, waits for its response
	task automatic issue(input rrp_cmd_e t, input logic [15:0] n, input logic [2:0] f, input logic b);
		int k;
		k = 0;
		while (!req_ready && k < 200) begin
			tick(1);
			k++;
		end
		req_type = t;
		{req_lba, req_len, req_flags, req_tb} = {32'h0000_0064, n, f, b};
		{req_valid, blocks, resel_seen} = {1'b1, 32'h0, 1'b0};
		fixd = 0;
		tick(1);
		req_valid = 1'b0;
		k = 0;
		while (!rsp_valid && k < 300) begin
			tick(1);
			k++;
		end
		chk(32'(rsp_valid), 32'h1);
	endtask
	// every recovery mode over retry, correctable, clean blocks
	task automatic t_modes();
		logic [2:0] fl[6] = '{3'b000, 3'b100, 3'b101, 3'b110, 3'b111, 3'b001};
		logic [3:0] ek[6] = '{SK_NONE, SK_RECOVERED, SK_MEDIUM, SK_RECOVERED, SK_RECOVERED, SK_MEDIUM};
		int         eo[6] = '{0, 1, 1, 0, 0, 1};
		int         eb[6] = '{3, 3, 1, 1, 1, 1};
		int         ef[6] = '{2, 2, 1, 1, 1, 1};
		for (int i = 0; i < 6; i++) begin
			issue(RRP_CMD_FLAGS, 16'h0000, fl[i], 1'b0);
			chk(32'(rsp_chk), 32'h0);
			mq = '{RRP_BLK_RETRY, RRP_BLK_ECC, RRP_BLK_CLEAN};
			issue(RRP_CMD_READ, 16'h0003, fl[i], 1'b0);
			chk(32'(rsp_key), 32'(ek[i]));
			chk(32'(rsp_chk), 32'(ek[i] != SK_NONE));
			if (ek[i] != SK_NONE) chk(rsp_info, 32'h64 + 32'(eo[i]));
			chk(32'(blocks), 32'(eb[i]));
			chk(32'(fixd), 32'(ef[i]));
			mq.delete();
		end
	endtask
	// unrecoverable block, with and without sending its data
	task automatic t_bad();
		for (int b = 0; b < 2; b++) begin
			// send_bad_block travels with the flags command
			issue(RRP_CMD_FLAGS, 16'h0000, 3'b000, 1'(b));
			mq = '{RRP_BLK_CLEAN, RRP_BLK_BAD, RRP_BLK_CLEAN};
			issue(RRP_CMD_READ, 16'h0003, 3'b000, 1'(b));
			chk(32'(rsp_key), 32'(SK_MEDIUM));
			chk(rsp_info, 32'h65);
			chk(32'(blocks), 32'(1 + b));
			chk(32'(fixd), 32'h0);
			mq.delete();
		end
	endtask
	// both refused flag codes, earlier flags stay in force
	task automatic t_illegal();
		issue(RRP_CMD_FLAGS, 16'h0000, 3'b100, 1'b0);
		for (int i = 2; i < 4; i++) begin
			issue(RRP_CMD_FLAGS, 16'h0000, 3'(i), 1'b0);
			chk(32'(rsp_key), 32'(SK_ILLEGAL));
			chk(32'(rsp_chk), 32'h1);
		end
		mq = '{RRP_BLK_RETRY, RRP_BLK_CLEAN};
		issue(RRP_CMD_READ, 16'h0002, 3'b000, 1'b0);
		chk(32'(rsp_key), 32'(SK_RECOVERED));
		chk(rsp_info, 32'h64);
		// zero-length transfer answers at once without error
		issue(RRP_CMD_WRITE, 16'h0000, 3'b000, 1'b0);
		chk(32'({rsp_chk, rsp_key}), 32'h0);
	endtask
	// thresholds through a page write, then reselect at the edges
	task automatic t_resel();
		logic [7:0] bl[4] = '{8'h3F, 8'h40, 8'h11, 8'h10};
		{req_rthr, req_wthr} = {8'h40, 8'h10};
		issue(RRP_CMD_PAGE, 16'h0000, 3'b000, 1'b0);
		chk(32'(rsp_chk), 32'h0);
		chk(32'({read_thr, write_thr}), 32'h4010);
		for (int i = 0; i < 4; i++) begin
			buf_level = bl[i];
			mq = '{RRP_BLK_CLEAN, RRP_BLK_CLEAN};
			issue(i < 2 ? RRP_CMD_READ : RRP_CMD_WRITE, 16'h0002, 3'b000, 1'b0);
			chk(32'(resel_seen), 32'(i % 2));
			mq.delete();
		end
		chk(32'(lat), 32'h3);
		{req_rthr, req_wthr} = {8'h00, 8'h00};
		issue(RRP_CMD_PAGE, 16'h0000, 3'b000, 1'b0);
		chk(32'({read_thr, write_thr}), 32'h20C0);
	endtask
	// raw page bytes into the second target, one byte overridden
	task automatic pg2(input logic [3:0] bi, input logic [7:0] bv);
		for (int i = 0; i < 16; i++) begin
			{l2.pg_valid, l2.pg_idx, l2.pg_last} = {1'b1, 4'(i), 1'(i == 15)};
			l2.pg_data = (4'(i) == bi) ? bv : (i == 0) ? 8'h02 : (i == 1) ? 8'h0E : (i < 4) ? 8'h55 : 8'h00;
			tick(1);
		end
		{l2.pg_valid, l2.pg_last} = 2'b00;
		chk(32'(l2.done), 32'h1);
		tick(1);
	endtask
	task automatic t_page2();
		logic [3:0] bi[8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h9, 4'hA, 4'hC};
		logic [7:0] bv[8] = '{8'h03, 8'h05, 8'h01, 8'h80, 8'h01, 8'h01, 8'h01, 8'h01};
		for (int i = 0; i < 8; i++) begin
			pg2(bi[i], bv[i]);
			chk(32'({l2.chk_cond, l2.sense_key}), 32'h15);
			chk(32'({thr2_r, thr2_w}), 32'h20C0);
		end
		pg2(4'h1, 8'h00);
		chk(32'(l2.chk_cond), 32'h0);
		chk(32'({thr2_r, thr2_w}), 32'h5555);
	endtask
	task automatic results();
		if (err_total == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// main sequence
	initial begin
		{clk, rstn, req_valid, req_tb, media_valid, buf_level} = '0;
		req_type     = RRP_CMD_READ;
		media_status = RRP_BLK_CLEAN;
		l2.cmd_type  = RRP_CMD_READ;
		{req_lba, req_len, req_flags, req_rthr, req_wthr} = '0;
		{l2.cmd_valid, l2.cmd_lba, l2.cmd_len, l2.cmd_flags, l2.cmd_tb} = '0;
		{l2.pg_valid, l2.pg_idx, l2.pg_data, l2.pg_last} = '0;
		tick(4);
		rstn = 1'b1;
		chk(32'({read_thr, write_thr}), 32'h20C0);
		t_modes();
		t_bad();
		t_illegal();
		t_resel();
		t_page2();
		results();
	end
endmodule
`default_nettype wire
